// file: rtl/arb_pkg.sv
// Purpose: Shared constants and types of the channel arbiter and its adapter end
// Assumes: core_clk at 100 MHz
// Notes:   Register offsets are byte addresses on the APB side
package arb_pkg;

  // ==========================================================================
  // Clock and timing
  localparam int unsigned CLK_NS        = 10;
  localparam int unsigned ARB_MIN_NS    = 300;
  localparam int unsigned ARB_EXT_NS    = 600;
  localparam int unsigned ARB_MIN_CYC   = (ARB_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned ARB_EXT_CYC   = (ARB_EXT_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned BUS_TMO_NS    = 7800;
  localparam int unsigned BUS_TMO_CYC   = BUS_TMO_NS / CLK_NS;
  localparam int unsigned CHRST_NS      = 1000;
  localparam int unsigned CHRST_CYC     = (CHRST_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned ID_WIN_PWR_MS = 1000;
  localparam int unsigned ID_WIN_SFT_MS = 740;
  localparam int unsigned ID_WIN_PWR_CYC = ID_WIN_PWR_MS * (1000000 / CLK_NS);
  localparam int unsigned ID_WIN_SFT_CYC = ID_WIN_SFT_MS * (1000000 / CLK_NS);
  localparam int unsigned ADP_READY_CYC = 1000;

  // ==========================================================================
  // Register map
  localparam logic [11:0] ADDR_CTRL  = 12'h090;
  localparam logic [11:0] ADDR_ISTS  = 12'h094;
  localparam logic [11:0] ADDR_ICLR  = 12'h098;
  localparam logic [11:0] ADDR_IEN   = 12'h09c;
  localparam logic [11:0] ADDR_CHRST = 12'h0a0;

  localparam int unsigned CTRL_CPU_EN = 7;
  localparam int unsigned CTRL_FORCE  = 6;
  localparam int unsigned CTRL_EXT    = 5;
  localparam int unsigned CTRL_NMI    = 6;
  localparam int unsigned CTRL_TMO    = 5;
  localparam int unsigned CHRST_GO    = 0;
  localparam int unsigned CHRST_PWR   = 1;

  localparam int unsigned IRQ_TMO  = 0;
  localparam int unsigned IRQ_NMI  = 1;
  localparam int unsigned IRQ_DEF  = 2;
  localparam int unsigned IRQ_CHK  = 3;
  localparam int unsigned IRQ_W    = 4;

  localparam int unsigned LVL_N    = 16;
  localparam logic [15:0] ID_NOT_READY = 16'h0000;

  typedef enum logic [1:0] {ST_CPU, ST_ARB, ST_GRANT} arb_state_t;

endpackage : arb_pkg

// file: rtl/chan_adapter.sv
// Purpose: Adapter end: requests the channel, reports its ID and faults
// Assumes: Requester holds want until its transfer is over
// Notes:   ID reads as not ready for READY_CYC cycles after channel reset
`timescale 1ns/100ps
module chan_adapter
  import arb_pkg::*;
#(
  parameter logic [3:0]  MY_LVL    = 4'h3,
  parameter logic [15:0] CARD_ID   = 16'h5a5a, // Arbitrary value
  parameter int unsigned READY_CYC = ADP_READY_CYC
) (
  input  wire logic core_clk,
  input  wire logic srst,
  chan_if.adapter   link,
  input  wire logic want,
  output logic      granted,
  input  wire logic err,
  input  wire logic err_clr,
  output logic      id_ready
);

  typedef struct packed {
    logic        preempt;
    logic        chk;
    logic [31:0] id_cnt;
    logic        id_ok;
  } adp_state_t;

  adp_state_t s_q;
  adp_state_t s_d;

  // ==========================================================================
  // Next state
  always_comb begin
    s_d = s_q;
    s_d.preempt = want & ~link.chan_reset;
    // Faults go out only as the asynchronous channel check level
    if (err_clr) s_d.chk = 1'b0; // [RQ14]
    if (err) s_d.chk = 1'b1; // [RQ14]
    if (link.chan_reset) begin
      s_d.id_cnt = '0;
      s_d.id_ok  = 1'b0; // [RQ12]
    end else if (!s_q.id_ok) begin
      // READY_CYC is kept below the shorter ID window
      if (s_q.id_cnt >= 32'(READY_CYC - 1)) s_d.id_ok = 1'b1; // [RQ12] [RQ13]
      else s_d.id_cnt = s_q.id_cnt + 32'h1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================================================
  // Outputs
  assign link.preempt = s_q.preempt;
  assign link.arb_lvl = MY_LVL;
  assign link.chan_chk = s_q.chk; // [RQ14]
  assign link.card_id = s_q.id_ok ? CARD_ID : ID_NOT_READY; // [RQ12]
  assign granted = s_q.preempt & ~link.arb_gnt & (link.grant_lvl == MY_LVL);
  assign id_ready = s_q.id_ok;

endmodule : chan_adapter

// file: rtl/chan_arbiter.sv
// Purpose: Central arbitration control point with APB register access
// Assumes: Lowest level number wins; all inputs synchronous to core_clk
// Notes:   Read data is latched in the APB setup cycle
// Function
// (RQ1) Grant channel to one of 16 levels
// (RQ2) Control register decoded at 0x90
// (RQ3) Bit 7 write enables processor during arbitration
// (RQ4) Bit 7 read mirrors processor enable
// (RQ5) Bit 6 write forces arbitration state
// (RQ6) Bit 6 read shows NMI masked arbitration
// (RQ7) Software forces arbitration only for diagnostics
// (RQ8) Bit 5 stretches minimum arbitration 300->600 ns
// (RQ9) Bit 5 read shows timeout, clears bit 6
// (RQ10) Software writes bits 4..0 as zero
// (RQ11) Bits 3..0 read last granted level
// (RQ12) Not-ready ID allowed 1 s after power reset
// (RQ13) Soft channel reset shrinks window to 740 ms
// (RQ14) Adapters report faults by asynchronous check
// (RQ15) Capture winning level at end of grant
`timescale 1ns/100ps
module chan_arbiter
  import arb_pkg::*;
#(
  parameter int unsigned WIN_PWR_CYC = ID_WIN_PWR_CYC,
  parameter int unsigned WIN_SFT_CYC = ID_WIN_SFT_CYC
) (
  input  wire logic        core_clk,
  input  wire logic        srst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  chan_if.central          link,
  input  wire logic [15:0] local_req,
  input  wire logic        nmi,
  output logic             cpu_cycle_ok,
  output logic             card_defective,
  output logic             irq
);

  typedef struct packed {
    arb_state_t        st;
    logic [7:0]        arb_cnt;
    logic [15:0]       tmo_cnt;
    logic [3:0]        owner;
    logic [3:0]        last_lvl;
    logic              cpu_en;
    logic              force_arb;
    logic              ext_arb;
    logic              nmi_mask;
    logic              tmo;
    logic [IRQ_W-1:0]  ists;
    logic [IRQ_W-1:0]  ien;
    logic              chk_prev;
    logic [7:0]        rst_cnt;
    logic              rst_on;
    logic              win_on;
    logic              win_pwr;
    logic [31:0]       win_cnt;
    logic              defect;
    logic [31:0]       rdata;
  } arb_regs_t;

  arb_regs_t s_q;
  arb_regs_t s_d;

  // ==========================================================================
  // Helpers
  function automatic logic mapped(input logic [11:0] a);
    return (a == ADDR_CTRL) || (a == ADDR_ISTS) || (a == ADDR_ICLR) ||
           (a == ADDR_IEN) || (a == ADDR_CHRST);
  endfunction : mapped

  function automatic logic [3:0] pick_lvl(input logic [15:0] r);
    logic [3:0] w;
    w = 4'h0;
    for (int i = LVL_N - 1; i >= 0; i--) begin
      if (r[i]) w = 4'(i);
    end
    return w;
  endfunction : pick_lvl

  logic [15:0] req;
  logic        any_req;
  logic        hold_arb;
  logic [7:0]  min_cyc;
  logic        wr;
  logic        rd;
  logic [31:0] win_lim;

  // ==========================================================================
  // Request gathering
  always_comb begin
    req = local_req;
    if (link.preempt) req[link.arb_lvl] = 1'b1; // [RQ1]
  end

  assign any_req  = |req;
  assign hold_arb = s_q.force_arb | s_q.nmi_mask; // [RQ5]
  assign min_cyc  = s_q.ext_arb ? 8'(ARB_EXT_CYC) : 8'(ARB_MIN_CYC); // [RQ8]
  assign wr       = psel & penable & pwrite;
  assign rd       = psel & penable & ~pwrite;
  assign win_lim  = s_q.win_pwr ? 32'(WIN_PWR_CYC) : 32'(WIN_SFT_CYC); // [RQ12] [RQ13]

  // ==========================================================================
  // Next state
  always_comb begin
    s_d = s_q;
    s_d.chk_prev = link.chan_chk;

    // Read data is taken in the setup cycle
    if (psel && !penable) begin
      unique case (paddr)
        ADDR_CTRL: s_d.rdata = {24'h0, s_q.cpu_en, s_q.nmi_mask, // [RQ4] [RQ6]
                                s_q.tmo, 1'b0, s_q.last_lvl}; // [RQ9] [RQ11]
        ADDR_ISTS:  s_d.rdata = {28'h0, s_q.ists};
        ADDR_IEN:   s_d.rdata = {28'h0, s_q.ien};
        ADDR_CHRST: s_d.rdata = {30'h0, s_q.defect, s_q.win_on | s_q.rst_on};
        default:    s_d.rdata = 32'h0;
      endcase
    end

    // Reading the timeout as one releases the forced state
    if (rd && paddr == ADDR_CTRL && s_q.rdata[CTRL_TMO]) begin
      s_d.force_arb = 1'b0; // [RQ9]
      s_d.tmo       = 1'b0;
    end

    if (wr) begin
      case (paddr)
        ADDR_CTRL: begin // [RQ2]
          // Bits 4..0 carry no meaning on write
          s_d.cpu_en    = pwdata[CTRL_CPU_EN]; // [RQ3] [RQ10]
          s_d.force_arb = pwdata[CTRL_FORCE]; // [RQ5]
          s_d.ext_arb   = pwdata[CTRL_EXT]; // [RQ8]
          if (!pwdata[CTRL_FORCE]) s_d.nmi_mask = 1'b0;
        end
        ADDR_ICLR: s_d.ists = s_q.ists & ~pwdata[IRQ_W-1:0];
        ADDR_IEN:  s_d.ien = pwdata[IRQ_W-1:0];
        ADDR_CHRST: begin
          if (pwdata[CHRST_GO]) begin
            s_d.rst_on  = 1'b1;
            s_d.rst_cnt = 8'(CHRST_CYC);
            s_d.win_on  = 1'b0;
            s_d.win_pwr = pwdata[CHRST_PWR]; // [RQ13]
            s_d.defect  = 1'b0;
          end
        end
        default: ;
      endcase
    end

    // Arbitration state machine
    case (s_q.st)
      ST_CPU: begin
        s_d.arb_cnt = 8'h0;
        if (hold_arb || any_req) s_d.st = ST_ARB;
      end
      ST_ARB: begin
        if (s_q.arb_cnt < min_cyc) s_d.arb_cnt = s_q.arb_cnt + 8'h1; // [RQ8]
        if (!hold_arb && s_q.arb_cnt >= min_cyc - 8'h1) begin
          if (any_req) begin
            s_d.st      = ST_GRANT;
            s_d.owner   = pick_lvl(req); // [RQ1]
            s_d.tmo_cnt = 16'h0;
          end else begin
            s_d.st = ST_CPU;
          end
        end
      end
      ST_GRANT: begin
        s_d.tmo_cnt = s_q.tmo_cnt + 16'h1;
        if (!req[s_q.owner] || hold_arb || s_q.tmo_cnt == 16'(BUS_TMO_CYC - 1)) begin
          s_d.st       = ST_ARB;
          s_d.arb_cnt  = 8'h0;
          s_d.last_lvl = s_q.owner; // [RQ15] [RQ11]
          if (req[s_q.owner] && !hold_arb) begin
            s_d.tmo           = 1'b1; // [RQ9]
            s_d.ists[IRQ_TMO] = 1'b1;
          end
        end
      end
      default: s_d.st = ST_CPU;
    endcase

    // Channel reset pulse, then the not-ready ID window
    if (s_q.rst_on) begin
      if (s_q.rst_cnt <= 8'h1) begin
        s_d.rst_on  = 1'b0;
        s_d.win_on  = 1'b1;
        s_d.win_cnt = 32'h0;
      end else begin
        s_d.rst_cnt = s_q.rst_cnt - 8'h1;
      end
    end else if (s_q.win_on) begin
      if (link.card_id != ID_NOT_READY) begin
        s_d.win_on = 1'b0; // [RQ12]
      end else if (s_q.win_cnt >= win_lim - 32'h1) begin
        s_d.win_on        = 1'b0;
        s_d.defect        = 1'b1; // [RQ12] [RQ13]
        s_d.ists[IRQ_DEF] = 1'b1;
      end else begin
        s_d.win_cnt = s_q.win_cnt + 32'h1;
      end
    end

    // Events win over a clear in the same cycle
    if (nmi) begin
      s_d.nmi_mask      = 1'b1; // [RQ6]
      s_d.ists[IRQ_NMI] = 1'b1;
    end
    if (link.chan_chk && !s_q.chk_prev) s_d.ists[IRQ_CHK] = 1'b1; // [RQ14]
  end

  // ==========================================================================
  // State register
  always_ff @(posedge core_clk) begin
    if (srst) begin
      s_q    <= '0; // [RQ3] [RQ5] [RQ8]
      s_q.st <= ST_CPU;
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================================================
  // Outputs
  assign prdata          = s_q.rdata;
  assign pready          = psel & penable;
  assign pslverr         = psel & penable & ~mapped(paddr); // [RQ2]
  assign link.arb_gnt    = (s_q.st != ST_GRANT);
  assign link.grant_lvl  = s_q.owner;
  assign link.chan_reset = s_q.rst_on;
  assign cpu_cycle_ok    = (s_q.st == ST_CPU) ||
                           (s_q.st == ST_ARB && s_q.cpu_en); // [RQ3]
  assign card_defective  = s_q.defect;
  assign irq             = |(s_q.ists & s_q.ien);

endmodule : chan_arbiter

// file: rtl/chan_if.sv
// Purpose: Channel link between the central arbiter and one adapter
// Assumes: Both ends on core_clk
// Notes:   Arbitration bus reduced to one level per adapter
`timescale 1ns/100ps
interface chan_if;
  logic        preempt;
  logic [3:0]  arb_lvl;
  logic        arb_gnt;
  logic [3:0]  grant_lvl;
  logic        chan_reset;
  logic [15:0] card_id;
  logic        chan_chk;

  modport central (
    output arb_gnt, grant_lvl, chan_reset,
    input  preempt, arb_lvl, card_id, chan_chk
  );
  modport adapter (
    input  arb_gnt, grant_lvl, chan_reset,
    output preempt, arb_lvl, card_id, chan_chk
  );
endinterface : chan_if

// file: tb/chan_link_asserts.sv
// Purpose: Assertions on the link between the arbiter and its adapter
// Assumes: One clock; srst synchronous, active high
// Notes:   Span counters measure arbitration, grant and reset lengths
`timescale 1ns/100ps
module chan_link_asserts
  import arb_pkg::*;
(
  input wire logic        core_clk,
  input wire logic        srst,
  input wire logic        preempt,
  input wire logic [3:0]  arb_lvl,
  input wire logic        arb_gnt,
  input wire logic [3:0]  grant_lvl,
  input wire logic        chan_reset,
  input wire logic [15:0] card_id,
  input wire logic        chan_chk
);
  // ==========================================================================
  // Span counters
  logic [31:0] arb_q, gnt_q, rst_q;
  always_ff @(posedge core_clk) begin
    if (srst) begin
      arb_q <= 32'h0;
      gnt_q <= 32'h0;
      rst_q <= 32'h0;
    end else begin
      arb_q <= arb_gnt ? arb_q + 32'h1 : 32'h0;
      gnt_q <= arb_gnt ? 32'h0 : gnt_q + 32'h1;
      rst_q <= chan_reset ? rst_q + 32'h1 : 32'h0;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);
  // ==========================================================================
  // Properties
  property p_lvl_stable;
    !arb_gnt && !$past(arb_gnt) |-> $stable(grant_lvl);
  endproperty
  a_lvl_stable: assert property (p_lvl_stable) else $error("owner changed in grant");
  property p_owner_req;
    !arb_gnt && grant_lvl == arb_lvl |-> preempt || $past(preempt);
  endproperty
  a_owner_req: assert property (p_owner_req) else $error("grant without request");
  property p_min_arb;
    $fell(arb_gnt) |-> arb_q >= ARB_MIN_CYC;
  endproperty
  a_min_arb: assert property (p_min_arb) else $error("arbitration too short");
  property p_release;
    $fell(preempt) && !arb_gnt && grant_lvl == arb_lvl |-> ##[0:2] arb_gnt;
  endproperty
  a_release: assert property (p_release) else $error("grant not released");
  property p_max_grant;
    gnt_q <= BUS_TMO_CYC + 2;
  endproperty
  a_max_grant: assert property (p_max_grant) else $error("grant outlived timeout");
  property p_rst_hold;
    $rose(chan_reset) |-> chan_reset [*8];
  endproperty
  a_rst_hold: assert property (p_rst_hold) else $error("channel reset too short");
  property p_rst_len;
    rst_q <= CHRST_CYC;
  endproperty
  a_rst_len: assert property (p_rst_len) else $error("channel reset too long");
  property p_id_rst;
    chan_reset |=> card_id == ID_NOT_READY;
  endproperty
  a_id_rst: assert property (p_id_rst) else $error("id ready in reset");
  property p_id_wait;
    $fell(chan_reset) |-> (card_id == ID_NOT_READY) [*8];
  endproperty
  a_id_wait: assert property (p_id_wait) else $error("id ready too soon");
endmodule : chan_link_asserts

// file: tb/test_channel_central_arbiter.sv
// Purpose: Self-checking bench of the arbiter facing one adapter
// Assumes: Shortened window and ready counts
// Notes:   Each APB transfer ends with one idle cycle
`timescale 1ns/100ps
module test_channel_central_arbiter;
  import arb_pkg::*;
  logic        core_clk, srst, psel, penable, pwrite, nmi, want, err, err_clr, e;
  logic        pready, pslverr, cpu_cycle_ok, card_defective, irq, granted, id_ready;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [15:0] local_req;
  int          fails, samples_checked, n;
  chan_if link();
  chan_arbiter #(.WIN_PWR_CYC(2000), .WIN_SFT_CYC(1500)) chan_arbiter_inst (
    .core_clk(core_clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .link(link.central), .local_req(local_req), .nmi(nmi), .cpu_cycle_ok(cpu_cycle_ok),
    .card_defective(card_defective), .irq(irq));
  chan_adapter #(.READY_CYC(100)) chan_adapter_inst (
    .core_clk(core_clk), .srst(srst), .link(link.adapter), .want(want),
    .granted(granted), .err(err), .err_clr(err_clr), .id_ready(id_ready));
  chan_link_asserts chan_link_asserts_inst (
    .core_clk(core_clk), .srst(srst), .preempt(link.preempt), .arb_lvl(link.arb_lvl),
    .arb_gnt(link.arb_gnt), .grant_lvl(link.grant_lvl), .chan_reset(link.chan_reset),
    .card_id(link.card_id), .chan_chk(link.chan_chk));
  // ==========================================================================
  // Tasks
  task conclude;
    $display("checked %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : conclude
  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask : apb
  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task rd(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(r, exp);
  endtask : rd
  task cyc(input int k);
    repeat (k) @(posedge core_clk);
  endtask : cyc
  // ==========================================================================
  // Clock, watchdog and tests
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  initial begin
    cyc(60000);
    fails++;
    conclude();
  end
  initial begin
    {srst, psel, penable, pwrite, nmi, want, err, err_clr} = 8'h80;
    paddr = 12'h0;
    pwdata = 32'h0;
    local_req = 16'h0;
    cyc(12);
    srst <= 1'b0;
    cyc(1);
    rd(ADDR_CTRL, 32'h0);
    apb(1'b0, 12'hffc, 32'h0);
    chk(e, 1);
    chk(r, 0);
    for (int x = 0; x < 2; x++) begin
      wr(ADDR_CTRL, x ? 32'ha0 : 32'h0);
      // Let the previous arbitration run out so the count starts from idle
      cyc(2 * ARB_EXT_CYC);
      want <= 1'b1;
      n = 0;
      while (granted !== 1'b1) begin
        cyc(1);
        n++;
        if (n == 6) chk(cpu_cycle_ok, x);
      end
      chk(n >= (x ? ARB_EXT_CYC : ARB_MIN_CYC) && n < (x ? ARB_EXT_CYC : ARB_MIN_CYC) + 10, 1);
      want <= 1'b0;
      cyc(4);
      rd(ADDR_CTRL, x ? 32'h83 : 32'h03);
    end
    $display("test arbitration done");
    local_req <= 16'h0002;
    want <= 1'b1;
    while (link.arb_gnt !== 1'b0) cyc(1);
    chk({31'h0, granted}, 0);
    chk({28'h0, link.grant_lvl}, 1);
    wr(ADDR_CTRL, 32'h40);
    local_req <= 16'h0;
    cyc(100);
    chk(link.arb_gnt, 1);
    rd(ADDR_CTRL, 32'h01);
    wr(ADDR_CTRL, 32'h0);
    while (granted !== 1'b1) cyc(1);
    while (granted === 1'b1) cyc(1);
    want <= 1'b0;
    rd(ADDR_ISTS, 32'h1);
    chk(irq, 0);
    wr(ADDR_IEN, 32'h1);
    chk(irq, 1);
    wr(ADDR_CTRL, 32'h40);
    rd(ADDR_CTRL, 32'h23);
    rd(ADDR_CTRL, 32'h03);
    want <= 1'b1;
    while (granted !== 1'b1) cyc(1);
    want <= 1'b0;
    wr(ADDR_ICLR, 32'h1);
    chk(irq, 0);
    $display("test timeout done");
    nmi <= 1'b1;
    cyc(1);
    nmi <= 1'b0;
    rd(ADDR_CTRL, 32'h43);
    wr(ADDR_CTRL, 32'h0);
    wr(ADDR_ICLR, 32'hf);
    err <= 1'b1;
    cyc(1);
    err <= 1'b0;
    cyc(3);
    rd(ADDR_ISTS, 32'h8);
    err_clr <= 1'b1;
    cyc(1);
    err_clr <= 1'b0;
    for (int x = 1; x < 4; x += 2) begin
      wr(ADDR_CHRST, x);
      rd(ADDR_CHRST, 32'h1);
      while (id_ready !== 1'b1) cyc(1);
      cyc(3);
      rd(ADDR_CHRST, 32'h0);
      chk(card_defective, 0);
    end
    $display("test nmi and channel reset done");
    conclude();
  end
endmodule : test_channel_central_arbiter
